//--- verilog/mcm_pkg.sv
// package of constants for the processor clock and memory map block
package mcm_pkg;
  // clock divider
  localparam int          MCM_DIV_W          = 3;        // processor clock divider code width
  localparam logic [2:0]  MCM_DIV_MAX_CODE   = 3'h6;     // codes at or above this give the lowest rate
  localparam int          MCM_PRE_W          = 2;        // master predivide counter width
  // master divide ratios from the 250 MHz system clock toward each base rate
  localparam int          MCM_CLK_SYS_KHZ    = 250000;
  localparam int          MCM_BASE_HI_HZ     = 9830400;  // selection [1,0], code 000
  localparam int          MCM_BASE_MID_HZ    = 6553600;  // selection [0,1], code 000
  localparam int          MCM_BASE_LO_HZ     = 4915200;  // selection [0,0], code 000
  // phase increment of a 32-bit accumulator: f / f_sys * 2^32
  localparam logic [31:0] MCM_INC_HI  = 32'((64'(MCM_BASE_HI_HZ)  << 32) / (64'(MCM_CLK_SYS_KHZ) * 64'd1000));
  localparam logic [31:0] MCM_INC_MID = 32'((64'(MCM_BASE_MID_HZ) << 32) / (64'(MCM_CLK_SYS_KHZ) * 64'd1000));
  localparam logic [31:0] MCM_INC_LO  = 32'((64'(MCM_BASE_LO_HZ)  << 32) / (64'(MCM_CLK_SYS_KHZ) * 64'd1000));
  // program space
  localparam logic [15:0] MCM_RESET_PC       = 16'h0000;
  localparam logic [15:0] MCM_VEC_FIRST      = 16'h0003;
  localparam logic [15:0] MCM_VEC_STEP       = 16'h0008;
  localparam int          MCM_VEC_NUM        = 16;       // vector slots decoded
  localparam int          MCM_BANK_W         = 3;
  localparam logic [7:0]  MCM_SFR_BANK_ADDR  = 8'hb6;    // program_bank_select
  localparam logic [7:0]  MCM_SFR_PAGE_ADDR  = 8'hbf;    // page_address_high
  localparam logic [7:0]  MCM_BANK_RESET     = 8'h00;
  localparam logic [7:0]  MCM_PAGE_RESET     = 8'h00;
  localparam int          MCM_FLASH_AW       = 18;       // 256 KB flash byte address
  localparam int          MCM_CE_PROG_MAX    = 8192;     // compute engine program bytes at most
  // external data space
  localparam logic [15:0] MCM_SHARED_DATA_RAM_BASE      = 16'h0000;
  localparam logic [15:0] MCM_SHARED_DATA_RAM_LAST      = 16'h0fff;
  localparam logic [15:0] MCM_CE_AREA_LAST   = 16'h03ff; // first 1 KB left to the compute engine
  localparam logic [15:0] MCM_ADC_AREA_LAST  = 16'h003f; // converter result bytes
  localparam logic [15:0] MCM_CFG_BASE       = 16'h2000;
  localparam logic [15:0] MCM_CFG_LAST       = 16'h20ff;
  localparam logic [15:0] MCM_BAT_BASE       = 16'h20c0;
  localparam logic [15:0] MCM_BAT_LAST       = 16'h20c7;
  localparam int          MCM_CFG_AW         = 8;
endpackage : mcm_pkg

//--- verilog/mcm_xdec_if.sv
// interface carrying decoded external data selects between decoder and top
`timescale 1ns/1ps
`default_nettype none
interface mcm_xdec_if;
  logic [15:0] addr;     // full external data address
  logic        sel_shared_data_ram; // shared data ram selected
  logic        sel_cfg;  // configuration ram, volatile part
  logic        sel_bat;  // configuration ram, battery part
  modport dec (input addr, output sel_shared_data_ram, sel_cfg, sel_bat);
  modport top (output addr, input sel_shared_data_ram, sel_cfg, sel_bat);
endinterface : mcm_xdec_if
`default_nettype wire

//--- verilog/mcm_xdec.sv
// external data address decoder
`timescale 1ns/1ps
`default_nettype none
module mcm_xdec
  import mcm_pkg::*;
(
  mcm_xdec_if.dec x
);
  // range compares, all continuous
  wire in_shared_data_ram = (x.addr >= MCM_SHARED_DATA_RAM_BASE) && (x.addr <= MCM_SHARED_DATA_RAM_LAST);
  wire in_cfg  = (x.addr >= MCM_CFG_BASE) && (x.addr <= MCM_CFG_LAST);
  wire in_bat  = (x.addr >= MCM_BAT_BASE) && (x.addr <= MCM_BAT_LAST);
  // everything else selects nothing
  assign x.sel_shared_data_ram = in_shared_data_ram;
  assign x.sel_cfg  = in_cfg && !in_bat;
  assign x.sel_bat  = in_bat;
endmodule : mcm_xdec
`default_nettype wire

//--- verilog/mcm_top.sv
// processor clock enable divider and memory map decoding
//
// Contract
// - processor clock from divider code and select
// - code fetches to flash, data to data spaces
// - 64 KB program space for fetch and constants
// - upper program half banked by bank register
// - execution starts at address zero after reset
// - vectors from 0x0003 every eight bytes
// - 4 KB shared ram at data address zero
// - converter writes first 0x40 bytes unless slots zero
// - 8-bit pointer moves take page register high byte
// - volatile configuration ram at 2000-20ff minus battery
// - eight battery-backed bytes at 20c0-20c7
// - flash holds processor and engine programs
// - unmapped addresses reach no storage
`timescale 1ns/1ps
`default_nettype none
module mcm_top
  import mcm_pkg::*;
#(
  parameter int FLASH_AW = MCM_FLASH_AW   // flash byte address width
)(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // clock configuration
  input  wire logic [MCM_DIV_W-1:0] cpu_clock_divider,
  input  wire logic                 master_clock_high_select,
  input  wire logic                 master_clock_mid_select,
  output logic                      cpu_clock,           // one-cycle enable at processor rate
  // processor program side
  input  wire logic                 prog_req,            // fetch or code_constant_read
  input  wire logic [15:0]          prog_addr,
  output logic                      prog_rd,
  output logic [FLASH_AW-1:0]       flash_addr,
  output logic                      cpu_start_r,         // pulse: restart at reset address
  output logic [15:0]               cpu_start_pc,
  // vector lookup
  input  wire logic [3:0]           vec_num,
  output logic [15:0]               vec_addr,
  // special register port
  input  wire logic                 sfr_wr,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic [7:0]           sfr_wdata,
  output logic [7:0]                sfr_rdata,
  // external data side
  input  wire logic                 xd_req,
  input  wire logic                 xd_we,
  input  wire logic                 xd_short_ptr,        // 8-bit register pointer move
  input  wire logic [7:0]           xd_lo,
  input  wire logic [15:0]          wide_data_pointer,
  output logic                      shared_data_ram_cs,
  output logic                      cfg_cs,
  output logic                      bat_cs,
  output logic                      mem_we,
  output logic [15:0]               mem_addr,
  // converter writes
  input  wire logic [3:0]           mux_slots,
  input  wire logic                 adc_wr_req,
  input  wire logic [5:0]           adc_wr_addr,
  output logic                      adc_wr,
  output logic [5:0]                adc_wr_idx,
  output logic                      cpu_ce_area_hit      // processor touched engine area
);
  // ------------------------------------------------------------------
  // master rate: phase accumulator gives an enable at the base rate
  // one halving counter bit per divider step; the top code divides by 2^6
  localparam int DIV_CNT_W = int'(MCM_DIV_MAX_CODE);
  logic [31:0]          acc_r;
  logic [31:0]          acc_nxt;
  logic                 acc_cy;
  logic [DIV_CNT_W-1:0] div_cnt_r;       // binary counter of base pulses
  logic [MCM_DIV_W-1:0] div_eff;
  logic [31:0]          inc_sel;
  logic                 cpu_en_nxt;
  logic [DIV_CNT_W-1:0] div_mask;

  // selection [1,0], [0,1], [0,0]; [1,1] not allowed, treated as high
  assign inc_sel = master_clock_high_select ? MCM_INC_HI
                 : master_clock_mid_select  ? MCM_INC_MID : MCM_INC_LO;
  assign {acc_cy, acc_nxt} = {1'b0, acc_r} + {1'b0, inc_sel};
  // codes 110 and 111 share the lowest rate
  assign div_eff  = (cpu_clock_divider >= MCM_DIV_MAX_CODE) ? MCM_DIV_MAX_CODE
                  : cpu_clock_divider;
  // each code step halves: pulse when low div_eff bits of counter wrap
  // a counter narrower than the top code would fold the slow codes together
  assign div_mask = DIV_CNT_W'((1 << div_eff) - 1);
  assign cpu_en_nxt = acc_cy && ((div_cnt_r & div_mask) == div_mask);

  // accumulator and halving counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_r     <= '0;
      div_cnt_r <= '0;
      cpu_clock <= 1'b0;
    end else begin
      acc_r     <= acc_nxt;
      cpu_clock <= cpu_en_nxt;
      if (acc_cy) begin
        div_cnt_r <= div_cnt_r + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // special registers: bank select and page high byte
  logic [7:0] bank_r;
  logic [7:0] page_r;
  wire        bank_hit = sfr_addr == MCM_SFR_BANK_ADDR;
  wire        page_hit = sfr_addr == MCM_SFR_PAGE_ADDR;
  // only the low bank bits exist, upper bits read zero
  wire [7:0]  bank_rd  = {{(8-MCM_BANK_W){1'b0}}, bank_r[MCM_BANK_W-1:0]};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bank_r    <= MCM_BANK_RESET;
      page_r    <= MCM_PAGE_RESET;
      sfr_rdata <= 8'h00;
    end else begin
      if (sfr_wr && bank_hit) begin
        bank_r <= sfr_wdata;
      end
      if (sfr_wr && page_hit) begin
        page_r <= sfr_wdata;
      end
      // unimplemented addresses read zero
      sfr_rdata <= bank_hit ? bank_rd : page_hit ? page_r : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // program space mapping; lower half fixed, upper half banked
  logic [FLASH_AW-1:0] flash_nxt;
  wire                 prog_upper = prog_addr[15];                        // above 0x7fff
  // bank n places the upper window at flash (n+1)*32 KB; bank 0 keeps plain 64 KB
  wire [FLASH_AW-1:0]  bank_base  = FLASH_AW'({bank_r[MCM_BANK_W-1:0], 15'h0000});
  assign flash_nxt = prog_upper ? FLASH_AW'(bank_base + FLASH_AW'(prog_addr))
                                : FLASH_AW'(prog_addr);

  // fetches and constant reads both go to flash only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_rd    <= 1'b0;
      flash_addr <= '0;
    end else begin
      prog_rd    <= prog_req;
      flash_addr <= flash_nxt;
    end
  end

  // restart pulse after reset release with the reset address
  logic started_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      started_r    <= 1'b0;
      cpu_start_r  <= 1'b0;
      cpu_start_pc <= MCM_RESET_PC;
    end else begin
      started_r    <= 1'b1;
      cpu_start_r  <= !started_r;
      cpu_start_pc <= MCM_RESET_PC;
    end
  end

  // vector address: first plus eight per slot
  wire [15:0] vec_nxt = 16'(MCM_VEC_FIRST + 16'(vec_num) * MCM_VEC_STEP);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vec_addr <= MCM_VEC_FIRST;
    end else begin
      vec_addr <= vec_nxt;
    end
  end

  // ------------------------------------------------------------------
  // external data address: page register supplies high byte on short moves
  mcm_xdec_if xd ();
  assign xd.addr = xd_short_ptr ? {page_r, xd_lo} : wide_data_pointer;

  mcm_xdec u_xdec (
    .x (xd)
  );

  // chip selects only for mapped ranges; unmapped reach nothing, mem_we follows any write request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shared_data_ram_cs  <= 1'b0;
      cfg_cs   <= 1'b0;
      bat_cs   <= 1'b0;
      mem_we   <= 1'b0;
      mem_addr <= '0;
    end else begin
      shared_data_ram_cs  <= xd_req && xd.sel_shared_data_ram;
      cfg_cs   <= xd_req && xd.sel_cfg;
      bat_cs   <= xd_req && xd.sel_bat;
      mem_we   <= xd_req && xd_we;
      mem_addr <= xd.addr;
    end
  end

  // flag processor access into engine area; software should avoid it
  // flag only: the access itself still reaches the shared ram
  wire ce_hit = xd_req && xd.sel_shared_data_ram && (xd.addr <= MCM_CE_AREA_LAST);

  // converter writes continue while slot count is nonzero
  wire adc_go = adc_wr_req && (mux_slots != 4'h0);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adc_wr          <= 1'b0;
      adc_wr_idx      <= '0;
      cpu_ce_area_hit <= 1'b0;
    end else begin
      adc_wr          <= adc_go;
      adc_wr_idx      <= adc_wr_addr;
      cpu_ce_area_hit <= ce_hit;
    end
  end
endmodule : mcm_top
`default_nettype wire

//--- verification/mcm_top_monitor.sv
// concurrent checks on the clock enable and memory map outputs
`timescale 1ns/1ps
`default_nettype none
module mcm_top_monitor
  import mcm_pkg::*;
#(
  parameter int FLASH_AW = MCM_FLASH_AW  // flash byte address width
)(
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                rstn,
  // clock enable
  input wire logic                cpu_clock,
  // program side
  input wire logic                prog_req,
  input wire logic [15:0]         prog_addr,
  input wire logic                prog_rd,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic                cpu_start_r,
  input wire logic [15:0]         cpu_start_pc,
  // vector lookup
  input wire logic [3:0]          vec_num,
  input wire logic [15:0]         vec_addr,
  // external data side
  input wire logic                xd_req,
  input wire logic                xd_short_ptr,
  input wire logic [15:0]         wide_data_pointer,
  input wire logic                shared_data_ram_cs,
  input wire logic                cfg_cs,
  input wire logic                bat_cs,
  input wire logic [15:0]         mem_addr,
  // converter writes
  input wire logic [3:0]          mux_slots,
  input wire logic                adc_wr_req,
  input wire logic [5:0]          adc_wr_addr,
  input wire logic                adc_wr,
  input wire logic [5:0]          adc_wr_idx
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // wide pointer moves only, so the page register never hides the address
  wire logic wide = xd_req && !xd_short_ptr;
  a_clock_single: assert property (cpu_clock |=> !cpu_clock) else $error("processor enable too long");
  a_code_idle: assert property (!prog_req |=> !prog_rd) else $error("program read without request");
  a_low_prog: assert property (prog_req && !prog_addr[15] |=> prog_rd && flash_addr == FLASH_AW'($past(prog_addr)))
    else $error("low program address misplaced");
  a_start_pulse: assert property (cpu_start_r |-> cpu_start_pc == 16'h0000 ##1 !cpu_start_r [*3])
    else $error("start pulse wrong");
  a_vector_step: assert property ($past(rstn) |-> vec_addr == 16'h0003 + {$past(vec_num), 3'h0})
    else $error("vector address wrong");
  a_shared_ram: assert property (wide && wide_data_pointer <= 16'h0fff |=>
    shared_data_ram_cs && !cfg_cs && !bat_cs && mem_addr == $past(wide_data_pointer)) else $error("shared ram not selected");
  a_adc_write: assert property (adc_wr_req && mux_slots != 4'h0 |=> adc_wr && adc_wr_idx == $past(adc_wr_addr))
    else $error("converter write lost");
  a_adc_stop: assert property (mux_slots == 4'h0 |=> !adc_wr) else $error("converter wrote with zero slots");
  a_cfg_ram: assert property (wide && wide_data_pointer inside {[16'h2000:16'h20bf], [16'h20c8:16'h20ff]}
    |=> cfg_cs && !bat_cs && !shared_data_ram_cs) else $error("configuration ram not selected");
  a_bat_ram: assert property (wide && wide_data_pointer inside {[16'h20c0:16'h20c7]} |=> bat_cs && !cfg_cs)
    else $error("battery bytes not selected");
  a_no_storage: assert property (wide && !(wide_data_pointer inside {[16'h0000:16'h0fff], [16'h2000:16'h20ff]})
    |=> !shared_data_ram_cs && !cfg_cs && !bat_cs) else $error("unmapped address selected storage");
  a_idle_quiet: assert property (!xd_req |=> !shared_data_ram_cs && !cfg_cs && !bat_cs) else $error("select without request");
endmodule : mcm_top_monitor
bind mcm_top mcm_top_monitor #(.FLASH_AW(FLASH_AW)) u_mon (.*);
`default_nettype wire

//--- verification/mcm_cpu_model.sv
// processor model issuing program and external data requests
`timescale 1ns/1ps
`default_nettype none
module mcm_cpu_model (
  // clock
  input  wire logic        clk_sys,
  // requests toward the block
  output var  logic        prog_req,
  output var  logic [15:0] prog_addr,
  output var  logic        xd_req,
  output var  logic        xd_we,
  output var  logic        xd_short_ptr,
  output var  logic [7:0]  xd_lo,
  output var  logic [15:0] wide_data_pointer
);
  initial begin
    {prog_req, prog_addr, xd_req, xd_we, xd_short_ptr, xd_lo, wide_data_pointer} = '0;
  end
  // one fetch or constant read; released address inverted so it never lingers
  task automatic fetch(input logic [15:0] a);
    @(posedge clk_sys); #1;
    prog_req = 1'b1;
    prog_addr = a;
    @(posedge clk_sys); #1;
    prog_req = 1'b0;
    prog_addr = ~a;
  endtask : fetch
  // one external data write move, short or wide pointer
  // software data stays above the engine's first 1 KB; only the flag test enters it
  task automatic xmove(input logic s, input logic [7:0] lo, input logic [15:0] w);
    @(posedge clk_sys); #1;
    {xd_req, xd_we, xd_short_ptr, xd_lo, wide_data_pointer} = {2'b11, s, lo, w};
    @(posedge clk_sys); #1;
    {xd_req, xd_we, xd_short_ptr, xd_lo, wide_data_pointer} = {3'b000, ~lo, ~w};
  endtask : xmove
endmodule : mcm_cpu_model
`default_nettype wire

//--- verification/mcm_top_tb.sv
// self-checking bench of the clock and memory map block
`timescale 1ns/1ps
`default_nettype none
module mcm_top_tb;
  import mcm_pkg::*;
  logic             clk_sys = 1'b0, rstn = 1'b0, hi_sel = 1'b0, mid_sel = 1'b0, sfr_wr = 1'b0, adc_wr_req = 1'b0;
  logic [2:0]       div = 3'h0;
  logic [3:0]       vec_num = 4'h0, mux_slots = 4'h0;
  logic [7:0]       sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [5:0]       adc_wr_addr = 6'h00;
  wire logic        prog_req, xd_req, xd_we, xd_short_ptr, prog_rd, cpu_clock, cpu_start_r, mem_we, adc_wr, ce_hit;
  wire logic        shared_data_ram_cs, cfg_cs, bat_cs;
  wire logic [15:0] prog_addr, wdp, cpu_start_pc, vec_addr, mem_addr;
  wire logic [7:0]  xd_lo, sfr_rdata;
  wire logic [17:0] flash_addr;
  wire logic [5:0]  adc_wr_idx;
  int               error_cnt = 0, num_checks = 0, cyc = 0;
  mcm_cpu_model cpu (.clk_sys(clk_sys), .prog_req(prog_req), .prog_addr(prog_addr), .xd_req(xd_req), .xd_we(xd_we),
    .xd_short_ptr(xd_short_ptr), .xd_lo(xd_lo), .wide_data_pointer(wdp));
  mcm_top DUT (.clk_sys(clk_sys), .rstn(rstn), .cpu_clock_divider(div), .master_clock_high_select(hi_sel),
    .master_clock_mid_select(mid_sel), .cpu_clock(cpu_clock), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .flash_addr(flash_addr), .cpu_start_r(cpu_start_r), .cpu_start_pc(cpu_start_pc),
    .vec_num(vec_num), .vec_addr(vec_addr), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xd_req(xd_req), .xd_we(xd_we), .xd_short_ptr(xd_short_ptr), .xd_lo(xd_lo),
    .wide_data_pointer(wdp), .shared_data_ram_cs(shared_data_ram_cs), .cfg_cs(cfg_cs), .bat_cs(bat_cs), .mem_we(mem_we),
    .mem_addr(mem_addr), .mux_slots(mux_slots), .adc_wr_req(adc_wr_req), .adc_wr_addr(adc_wr_addr),
    .adc_wr(adc_wr), .adc_wr_idx(adc_wr_idx), .cpu_ce_area_hit(ce_hit));
  initial forever #2 clk_sys = ~clk_sys;
  // hang guard, sized above the rate counts that dominate the run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    step();
    sfr_wr = 1'b0;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    step();
    check(sfr_rdata, exp);
  endtask : sfr_read
  // counts enable pulses; the accumulator start phase allows one pulse of slack
  task automatic clk_rate(input int s, input logic [2:0] code);
    longint n, exp;
    n = 0;
    {hi_sel, mid_sel, div} = {s == 0, s == 1, code};
    step(4);
    repeat (8192) begin
      step();
      n += longint'(cpu_clock);
    end
    exp = 64'd8192 * (s == 0 ? MCM_BASE_HI_HZ : s == 1 ? MCM_BASE_MID_HZ : MCM_BASE_LO_HZ)
          / (64'd250000000 << (code > 3'h6 ? 6 : code));
    check(32'(n >= exp - 1 && n <= exp + 1), 32'h1);
  endtask : clk_rate
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    static logic [15:0] xa [12] = '{16'h0000, 16'h0fff, 16'h1000, 16'h1fff, 16'h2000, 16'h20bf, 16'h20c0, 16'h20c7,
                                    16'h20c8, 16'h20ff, 16'h2100, 16'hffff};
    static logic [2:0]  xs [12] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0};
    int                 st;
    st = 0;
    step(3);
    rstn = 1'b1;
    repeat (4) begin
      step();
      st += int'(cpu_start_r);
    end
    check(st, 1);
    check(cpu_start_pc, 16'h0000);
    sfr_read(8'hb6, 8'h00);
    sfr_read(8'hbf, 8'h00);
    sfr_write(8'ha0, 8'h5a);
    sfr_read(8'ha0, 8'h00);
    sfr_write(8'hb6, 8'hff);
    sfr_read(8'hb6, 8'h07);
    // banks 0 to 6 seen through the upper half, lower half never banked
    for (int b = 0; b < 7; b++) begin
      sfr_write(8'hb6, 8'(b));
      cpu.fetch(16'h8000 + 16'(b));
      check(flash_addr, 32'h8000 * (b + 1) + b);
      cpu.fetch(16'h7ffe - 16'(b));
      check({prog_rd, flash_addr}, {1'b1, 18'h07ffe - 18'(b)});
    end
    for (int v = 0; v < 16; v++) begin
      vec_num = 4'(v);
      step();
      check(vec_addr, 32'h3 + 8 * v);
    end
    // wide pointer across every range edge of the data map
    for (int i = 0; i < 12; i++) begin
      cpu.xmove(1'b0, 8'h00, xa[i]);
      check({shared_data_ram_cs, cfg_cs, bat_cs}, xs[i]);
      check(ce_hit, xa[i] <= 16'h03ff);
      check(mem_we, 1'b1);
      if (xs[i] != 3'h0) check(mem_addr, xa[i]);
    end
    sfr_write(8'hbf, 8'h20);
    cpu.xmove(1'b1, 8'hc3, 16'h0000);
    check({bat_cs, shared_data_ram_cs, mem_addr}, {2'b10, 16'h20c3});
    {mux_slots, adc_wr_req, adc_wr_addr} = {4'h1, 1'b1, 6'h3f};
    step();
    check({adc_wr, adc_wr_idx}, {1'b1, 6'h3f});
    mux_slots = 4'h0;
    step(2);
    check(adc_wr, 1'b0);
    adc_wr_req = 1'b0;
    for (int s = 0; s < 3; s++) begin
      foreach (xs[c]) if (c < 3) clk_rate(s, c == 0 ? 3'h0 : c == 1 ? 3'h3 : 3'h7);
    end
    finish_test();
  end
endmodule : mcm_top_tb
`default_nettype wire
